// ==== inc/slr_pkg.sv ====
package slr_pkg;
    localparam int ADDR_W = 12;
    localparam logic [11:0] A_SYNC_CTRL = 12'h03a;
    localparam logic [11:0] A_SYNC_STAT = 12'h03b;
    localparam logic [11:0] A_IF_PWR = 12'h200;
    localparam logic [11:0] A_IDLE_LANES = 12'h201;
    localparam logic [11:0] A_CDR_RST = 12'h206;
    localparam logic [11:0] A_CDR_CFG = 12'h230;
    localparam logic [11:0] A_EQ_CFG = 12'h268;
    localparam logic [11:0] A_PLL_EN = 12'h280;
    localparam logic [11:0] A_PLL_STAT = 12'h281;
    localparam logic [11:0] A_PLL_DIV = 12'h289;
    localparam logic [11:0] A_AUTOTUNE = 12'h2a7;
    localparam logic [11:0] A_LINK_CTRL = 12'h300;
    localparam logic [11:0] A_SUBCLASS = 12'h301;
    localparam logic [11:0] A_MF_DEL = 12'h304;
    localparam logic [11:0] A_MF_VAR = 12'h306;
    localparam logic [11:0] A_XBAR_LO = 12'h308;
    localparam logic [11:0] A_XBAR_HI = 12'h309;
    localparam logic [11:0] A_PORT_CFG = 12'h314;
    localparam logic [11:0] A_INVERT = 12'h334;
    localparam logic [11:0] A_DEV_ID = 12'h450;
    localparam logic [11:0] A_BANK_ID = 12'h451;
    localparam logic [11:0] A_LANE_ID = 12'h452;
    localparam logic [11:0] A_SCR_LANES = 12'h453;
    localparam logic [11:0] A_OCT_M1 = 12'h454;
    localparam logic [11:0] A_FRM_M1 = 12'h455;
    localparam logic [11:0] A_CONV_M1 = 12'h456;
    localparam logic [11:0] A_RES_M1 = 12'h457;
    localparam logic [11:0] A_SUB_BITS = 12'h458;
    localparam logic [11:0] A_VER_SMP = 12'h459;
    localparam logic [11:0] A_DENSITY = 12'h45a;
    localparam logic [11:0] A_CHECK = 12'h45d;
    localparam logic [11:0] A_DESKEW = 12'h46c;
    localparam logic [11:0] A_OCTETS = 12'h476;
    localparam logic [11:0] A_LANE_EN = 12'h47d;
    localparam int NREG = 34;
    // Field positions
    localparam int SCR_BIT = 7;
    localparam int REV_BIT = 5;
    localparam int CDR_HALF_BIT = 5;
    localparam int CDR_OVS_BIT = 1;
    localparam int PLL_DIV_FIX_BIT = 2;
    localparam int SYNC_EN_BIT = 7;
    localparam int SYNC_ARM_BIT = 6;
    localparam int SYNC_LOCK_BIT = 3;
    localparam int LINK_EN_BIT = 0;
    localparam logic [2:0] CDR_FIX_VAL = 3'h2;
    localparam logic [5:0] EQ_FIX_VAL = 6'h22;
    // Reset values
    localparam logic [7:0] RST_CDR_CFG = 8'h09;
    localparam logic [7:0] RST_EQ_CFG = 8'h22;
    localparam logic [7:0] RST_PLL_DIV = 8'h04;
    localparam logic [7:0] RST_IF_PWR = 8'hff;
    localparam logic [7:0] RST_ZERO = 8'h00;
    // Cycles from PLL enable to lock indication
    localparam int PLL_LOCK_CYC = 16;
    localparam int FIFO_DEPTH = 4;
    typedef enum logic [1:0] {SLR_SYNC_IDLE, SLR_SYNC_ARMED, SLR_SYNC_LOCKED} slr_sync_t;
endpackage

// ==== hdl/slr_fifo.sv ====
`timescale 1ns/1ns
`default_nettype none
module slr_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    // Clocking
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [WIDTH-1:0] mem_next [DEPTH];
    logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic push, pop;

    assign in_ready_o = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_reg != '0);
    assign out_data_o = mem_reg[rp_reg];

    always_comb begin
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        mem_next = mem_reg;
        wp_next = wp_reg;
        rp_next = rp_reg;
        cnt_next = cnt_reg;
        if (push) begin
            mem_next[wp_reg] = in_data_i;
            wp_next = (wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
        end
        if (pop) begin
            rp_next = (rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
        end
        if (push && !pop) begin
            cnt_next = cnt_reg + 1'b1;
        end else if (pop && !push) begin
            cnt_next = cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= '0;
            end
        end else if (clk_en_i) begin
            wp_reg <= wp_next;
            rp_reg <= rp_next;
            cnt_reg <= cnt_next;
            mem_reg <= mem_next;
        end
    end
endmodule
`default_nettype wire

// ==== hdl/slr_link_setup.sv ====
`timescale 1ns/1ns
`default_nettype none
module slr_link_setup
    import slr_pkg::*;
#(
    parameter int LANES = 4,
    parameter int LANE_W = 8,
    parameter int LOCK_CYC = PLL_LOCK_CYC
) (
    // Clock, reset, enable
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    // Register port
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // Serial PLL lock from the analog side
    input wire logic pll_locked_i,
    // SYSREF
    input wire logic sysref_i,
    // Physical lanes in
    input wire logic lane_valid_i,
    output logic lane_ready_o,
    input wire logic [LANES*LANE_W-1:0] lane_data_i,
    // Logical lanes out
    output logic data_valid_o,
    input wire logic data_ready_i,
    output logic [LANES*LANE_W-1:0] data_o,
    // Status and controls
    output logic link_enabled_o,
    output logic cdr_reset_o,
    output logic pll_enable_o
);
    localparam int DW = LANES*LANE_W;
    localparam int SW = $clog2(LANES);

    logic [7:0] regs_reg [NREG];
    logic [7:0] regs_next [NREG];
    logic [7:0] rdata_reg, rdata_next;
    logic [7:0] pll_cnt_reg, pll_cnt_next;
    logic pll_lock_reg, pll_lock_next;
    logic sysref_d_reg, sysref_d_next;
    slr_sync_t sync_reg, sync_next;
    logic [DW-1:0] mapped;
    logic fifo_in_ready;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode shared by read and write
    function automatic int reg_index(input logic [11:0] a);
        unique case (a)
            A_SYNC_CTRL: reg_index = 0;
            A_IF_PWR: reg_index = 1;
            A_IDLE_LANES: reg_index = 2;
            A_CDR_RST: reg_index = 3;
            A_CDR_CFG: reg_index = 4;
            A_EQ_CFG: reg_index = 5;
            A_PLL_EN: reg_index = 6;
            A_PLL_DIV: reg_index = 7;
            A_AUTOTUNE: reg_index = 8;
            A_LINK_CTRL: reg_index = 9;
            A_SUBCLASS: reg_index = 10;
            A_MF_DEL: reg_index = 11;
            A_MF_VAR: reg_index = 12;
            A_XBAR_LO: reg_index = 13;
            A_XBAR_HI: reg_index = 14;
            A_PORT_CFG: reg_index = 15;
            A_INVERT: reg_index = 16;
            A_DEV_ID: reg_index = 17;
            A_BANK_ID: reg_index = 18;
            A_LANE_ID: reg_index = 19;
            A_SCR_LANES: reg_index = 20;
            A_OCT_M1: reg_index = 21;
            A_FRM_M1: reg_index = 22;
            A_CONV_M1: reg_index = 23;
            A_RES_M1: reg_index = 24;
            A_SUB_BITS: reg_index = 25;
            A_VER_SMP: reg_index = 26;
            A_DENSITY: reg_index = 27;
            A_CHECK: reg_index = 28;
            A_DESKEW: reg_index = 29;
            A_OCTETS: reg_index = 30;
            A_LANE_EN: reg_index = 31;
            A_SYNC_STAT: reg_index = 32;
            A_PLL_STAT: reg_index = 33;
            default: reg_index = -1;
        endcase
    endfunction

    function automatic logic [7:0] reset_value(input int i);
        unique case (i)
            1: reset_value = RST_IF_PWR;
            4: reset_value = RST_CDR_CFG;
            5: reset_value = RST_EQ_CFG;
            7: reset_value = RST_PLL_DIV;
            default: reset_value = RST_ZERO;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Register file and status
    wire logic [7:0] sync_ctrl = regs_reg[0];
    wire logic link_en = regs_reg[9][LINK_EN_BIT];
    wire logic [7:0] invert_mask = regs_reg[16];
    wire logic [7:0] deskew_mask = regs_reg[29];
    wire logic [7:0] enable_mask = regs_reg[31];
    // Lane count minus one, so four lanes is stored as 3
    wire logic [4:0] lanes_m1 = regs_reg[20][4:0];
    wire logic scramble_en = regs_reg[20][SCR_BIT];
    wire logic proto_rev_b = regs_reg[26][REV_BIT];
    wire logic sysref_rise = sysref_i && !sysref_d_reg;

    always_comb begin
        int idx;
        idx = reg_index(reg_addr_i);
        regs_next = regs_reg;
        rdata_next = rdata_reg;
        pll_cnt_next = pll_cnt_reg;
        pll_lock_next = pll_lock_reg;
        sysref_d_next = sysref_i;
        sync_next = sync_reg;
        if (reg_wr_i && idx >= 0 && idx < 32) begin
            regs_next[idx] = reg_wdata_i;
            if (idx == 4) begin
                regs_next[4][4:2] = CDR_FIX_VAL;
            end
            if (idx == 7) begin
                regs_next[7][PLL_DIV_FIX_BIT] = 1'b1;
            end
            if (idx == 5) begin
                regs_next[5][5:0] = EQ_FIX_VAL;
            end
        end
        // Lock only once enabled for the settle time and analog lock seen
        // Uses the incoming enable so a disable write drops the status at once
        if (!regs_next[6][0]) begin
            pll_cnt_next = '0;
            pll_lock_next = 1'b0;
        end else if (pll_cnt_reg != 8'(LOCK_CYC)) begin
            pll_cnt_next = pll_cnt_reg + 1'b1;
        end else begin
            pll_lock_next = pll_locked_i;
        end
        // One-shot sync: 0x01 mode, 0x81 enable, 0xC1 arm
        if (!sync_ctrl[SYNC_EN_BIT]) begin
            sync_next = SLR_SYNC_IDLE;
        end else begin
            unique case (sync_reg)
                SLR_SYNC_IDLE: begin
                    if (sync_ctrl[SYNC_ARM_BIT]) begin
                        sync_next = SLR_SYNC_ARMED;
                    end
                end
                SLR_SYNC_ARMED: begin
                    if (sysref_rise) begin
                        sync_next = SLR_SYNC_LOCKED;
                        regs_next[0][SYNC_ARM_BIT] = 1'b0;
                    end
                end
                SLR_SYNC_LOCKED: begin
                    if (sync_ctrl[SYNC_ARM_BIT]) begin
                        sync_next = SLR_SYNC_ARMED;
                    end
                end
            endcase
        end
        regs_next[32] = {4'h0, (sync_next == SLR_SYNC_LOCKED), 3'h0};
        regs_next[33] = {7'h0, pll_lock_next};
        if (reg_rd_i) begin
            rdata_next = (idx >= 0) ? regs_reg[idx] : 8'h00;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < NREG; i++) begin
                regs_reg[i] <= reset_value(i);
            end
            rdata_reg <= 8'h00;
            pll_cnt_reg <= 8'h00;
            pll_lock_reg <= 1'b0;
            sysref_d_reg <= 1'b0;
            sync_reg <= SLR_SYNC_IDLE;
        end else if (clk_en_i) begin
            regs_reg <= regs_next;
            rdata_reg <= rdata_next;
            pll_cnt_reg <= pll_cnt_next;
            pll_lock_reg <= pll_lock_next;
            sysref_d_reg <= sysref_d_next;
            sync_reg <= sync_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Lane crossbar and polarity; each logical lane picks a physical lane
    // Limitation: crossbar holds four 2-bit selects per byte, up to four lanes
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            logic [SW-1:0] sel;
            logic on;
            assign sel = SW'(lane_sel(regs_reg[13], regs_reg[14], g));
            assign on = enable_mask[g] && (g <= int'(lanes_m1));
            assign mapped[g*LANE_W +: LANE_W] = !on ? '0 :
                (lane_data_i[sel*LANE_W +: LANE_W] ^ {LANE_W{invert_mask[g]}});
        end
    endgenerate

    function automatic int lane_sel(input logic [7:0] lo, input logic [7:0] hi, input int n);
        logic [15:0] v;
        v = {hi, lo};
        lane_sel = int'(v[n*2 +: 2]);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Lane data only flows once the link is enabled
    slr_fifo #(.WIDTH(DW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .clk_en_i(clk_en_i),
        .in_valid_i(lane_valid_i && link_en),
        .in_ready_o(fifo_in_ready),
        .in_data_i(mapped),
        .out_valid_o(data_valid_o),
        .out_ready_i(data_ready_i),
        .out_data_o(data_o)
    );

    assign lane_ready_o = fifo_in_ready && link_en;
    assign reg_rdata_o = rdata_reg;
    assign link_enabled_o = link_en;
    assign cdr_reset_o = !regs_reg[3][0];
    assign pll_enable_o = regs_reg[6][0];
endmodule
`default_nettype wire

// ==== tb/slr_tx_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module slr_tx_model (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // Control from bench
    input wire logic send_i,
    // Lane side
    input wire logic lane_ready_i,
    output logic lane_valid_o,
    output logic [31:0] lane_data_o,
    output logic [7:0] count_o
);
    logic took;
    logic [31:0] word;
    assign word = {4{count_o}} ^ 32'h3c5a_9600;
    // Idle lanes show the inverse so a stale word is never mistaken for data
    assign lane_data_o = lane_valid_o ? word : ~word;
    always @(posedge core_clk_i) begin
        took <= lane_valid_o && lane_ready_i;
    end
    // A word stands until the device has taken it
    always @(negedge core_clk_i) begin
        if (!rst_b_i) begin
            count_o <= 8'h00;
            lane_valid_o <= 1'b0;
        end else begin
            if (took) begin
                count_o <= count_o + 8'h01;
            end
            lane_valid_o <= send_i || (lane_valid_o && !took);
        end
    end
endmodule
`default_nettype wire

// ==== tb/slr_link_setup_sva.sv ====
`timescale 1ns/1ns
`default_nettype none
module slr_chk
    import slr_pkg::*;
(
    // Clock and register port
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    // Lanes and controls
    input wire logic lane_valid_i,
    input wire logic lane_ready_o,
    input wire logic data_valid_o,
    input wire logic link_enabled_o,
    input wire logic cdr_reset_o,
    input wire logic pll_enable_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_rd(a);
        reg_rd_i && clk_en_i && reg_addr_i == a;
    endsequence
    sequence s_wr(a);
        reg_wr_i && clk_en_i && reg_addr_i == a;
    endsequence
    ////////////////////////////////////////////////////////////
    a_cdr_fixed_field: assert property (s_rd(A_CDR_CFG) |=> reg_rdata_o[4:2] == CDR_FIX_VAL)
        else $error("cdr config fixed field wrong");
    a_pll_div_fixed: assert property (s_rd(A_PLL_DIV) |=> reg_rdata_o[PLL_DIV_FIX_BIT])
        else $error("pll divider fixed bit clear");
    a_eq_low_bits: assert property (s_rd(A_EQ_CFG) |=> reg_rdata_o[5:0] == EQ_FIX_VAL)
        else $error("equalizer low bits wrong");
    a_lock_needs_en: assert property (s_rd(A_PLL_STAT) and !pll_enable_o |=> !reg_rdata_o[0])
        else $error("pll lock shown while disabled");
    a_pll_en_write: assert property (s_wr(A_PLL_EN) |=> pll_enable_o == $past(reg_wdata_i[0]))
        else $error("pll enable not taken");
    a_link_en_write: assert property (s_wr(A_LINK_CTRL) |=> link_enabled_o == $past(reg_wdata_i[0]))
        else $error("link enable not taken");
    a_link_en_hold: assert property (!(reg_wr_i && clk_en_i && reg_addr_i == A_LINK_CTRL) |=> $stable(link_enabled_o))
        else $error("link enable changed alone");
    a_cdr_rst_write: assert property (s_wr(A_CDR_RST) |=> cdr_reset_o != $past(reg_wdata_i[0]))
        else $error("cdr reset wrong");
    a_lane_gate: assert property (!link_enabled_o |-> !lane_ready_o)
        else $error("lane taken while link off");
    a_out_has_cause: assert property ($rose(data_valid_o) |-> $past(lane_valid_i && lane_ready_o))
        else $error("output word without input");
endmodule
bind slr_link_setup slr_chk slr_chk_inst (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .lane_valid_i(lane_valid_i), .lane_ready_o(lane_ready_o),
    .data_valid_o(data_valid_o), .link_enabled_o(link_enabled_o),
    .cdr_reset_o(cdr_reset_o), .pll_enable_o(pll_enable_o)
);
`default_nettype wire

// ==== tb/tb_slr_link_setup.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_slr_link_setup;
    import slr_pkg::*;
    logic core_clk_i, rst_b_i, reg_wr_i, reg_rd_i, pll_locked_i, sysref_i, send, clk_en;
    logic lane_valid, lane_ready, data_valid_o, data_ready_i, link_en, cdr_rst, pll_en;
    logic [11:0] reg_addr_i;
    logic [7:0] reg_wdata_i, reg_rdata_o, txm_count, inv, en, nl;
    logic [15:0] xb;
    logic [31:0] lane_data, data_o;
    logic [31:0] q[$];
    int failures, checks, cyc;
    slr_link_setup slr_link_setup_inst (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .pll_locked_i(pll_locked_i), .sysref_i(sysref_i),
        .lane_valid_i(lane_valid), .lane_ready_o(lane_ready), .lane_data_i(lane_data),
        .data_valid_o(data_valid_o), .data_ready_i(data_ready_i), .data_o(data_o),
        .link_enabled_o(link_en), .cdr_reset_o(cdr_rst), .pll_enable_o(pll_en));
    slr_tx_model slr_tx_model_inst (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .send_i(send),
        .lane_ready_i(lane_ready), .lane_valid_o(lane_valid), .lane_data_o(lane_data), .count_o(txm_count));
    initial core_clk_i = 1'b0;
    always #50 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) begin
        if (data_valid_o === 1'b1 && data_ready_i) q.push_back(data_o);
        cyc++;
        if (cyc == 4000) begin
            failures++;
            stop_test();
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge core_clk_i);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(negedge core_clk_i);
        reg_wr_i = 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m);
        @(negedge core_clk_i);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        @(negedge core_clk_i);
        reg_rd_i = 1'b0;
        chk_byte(reg_rdata_o & m, e & m, $sformatf("read %h", a));
    endtask
    // Expected logical word for partner word k under the current lane settings
    function automatic logic [31:0] expw(input logic [7:0] k);
        logic [31:0] w, r;
        w = {4{k}} ^ 32'h3c5a_9600;
        for (int g = 0; g < 4; g++) begin
            r[8*g+:8] = w[8*xb[2*g+:2]+:8] ^ {8{inv[g]}};
            if (!en[g] || g > nl) r[8*g+:8] = 8'h00;
        end
        return r;
    endfunction
    // Fill the buffer with the sink stalled, then drain it with a gappy sink
    task automatic run_phase(input string name);
        logic [7:0] b;
        b = txm_count;
        q.delete();
        send = 1'b1;
        repeat (12) @(negedge core_clk_i);
        chk_byte({7'h00, lane_ready}, 8'h00, "ready when full");
        chk_byte(txm_count - b, 8'(FIFO_DEPTH), "fill count");
        for (int i = 0; i < 40; i++) begin
            @(negedge core_clk_i);
            data_ready_i = i[0] | i[2];
            if (i == 30) send = 1'b0;
        end
        data_ready_i = 1'b1;
        repeat (8) @(negedge core_clk_i);
        chk_byte(8'(q.size()), txm_count - b, "word count");
        foreach (q[i]) chk_word(q[i], expw(b + 8'(i)), "lane word");
        data_ready_i = 1'b0;
        $display("test %s done", name);
    endtask
    task automatic stop_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        {rst_b_i, reg_wr_i, reg_rd_i, pll_locked_i, sysref_i, send, data_ready_i} = 7'h00;
        clk_en = 1'b1;
        reg_addr_i = 12'h000;
        reg_wdata_i = 8'h00;
        repeat (12) @(negedge core_clk_i);
        rst_b_i = 1'b1;
        rd(A_IF_PWR, 8'hff, 8'hff);
        rd(A_CDR_CFG, 8'h09, 8'hff);
        rd(A_EQ_CFG, 8'h22, 8'hff);
        rd(A_PLL_DIV, 8'h04, 8'hff);
        rd(12'h123, 8'h00, 8'hff);
        wr(A_CDR_CFG, 8'h21);
        rd(A_CDR_CFG, 8'h29, 8'hff);
        wr(A_PLL_DIV, 8'h03);
        rd(A_PLL_DIV, 8'h07, 8'hff);
        wr(A_EQ_CFG, 8'hc0);
        rd(A_EQ_CFG, 8'he2, 8'hff);
        wr(A_VER_SMP, 8'h20);
        rd(A_VER_SMP, 8'h20, 8'hff);
        wr(A_MF_DEL, 8'h0a);
        rd(A_MF_DEL, 8'h0a, 8'hff);
        // A write while the enable is low must not land
        clk_en = 1'b0;
        wr(A_MF_VAR, 8'h33);
        clk_en = 1'b1;
        rd(A_MF_VAR, 8'h00, 8'hff);
        wr(A_MF_VAR, 8'h33);
        rd(A_MF_VAR, 8'h33, 8'hff);
        wr(A_SYNC_STAT, 8'hff);
        rd(A_SYNC_STAT, 8'h00, 8'h08);
        chk_byte({7'h00, cdr_rst}, 8'h01, "cdr reset idle");
        wr(A_CDR_RST, 8'h00);
        wr(A_CDR_RST, 8'h01);
        chk_byte({7'h00, cdr_rst}, 8'h00, "cdr released");
        $display("test registers done");
        wr(A_PLL_EN, 8'h01);
        chk_byte({7'h00, pll_en}, 8'h01, "pll enabled");
        pll_locked_i = 1'b1;
        rd(A_PLL_STAT, 8'h00, 8'h01);
        repeat (20) @(negedge core_clk_i);
        rd(A_PLL_STAT, 8'h01, 8'h01);
        wr(A_PLL_EN, 8'h00);
        chk_byte({7'h00, pll_en}, 8'h00, "pll disabled");
        rd(A_PLL_STAT, 8'h00, 8'h01);
        $display("test pll done");
        wr(A_SYNC_CTRL, 8'h01);
        wr(A_SYNC_CTRL, 8'h81);
        wr(A_SYNC_CTRL, 8'hc1);
        rd(A_SYNC_STAT, 8'h00, 8'h08);
        sysref_i = 1'b1;
        repeat (3) @(negedge core_clk_i);
        sysref_i = 1'b0;
        rd(A_SYNC_STAT, 8'h08, 8'h08);
        rd(A_SYNC_CTRL, 8'h81, 8'hff);
        wr(A_SYNC_CTRL, 8'h01);
        rd(A_SYNC_STAT, 8'h00, 8'h08);
        $display("test sync done");
        {xb, inv, en, nl} = {16'h001b, 8'h05, 8'h0f, 8'h03};
        wr(A_IF_PWR, 8'h00);
        wr(A_DEV_ID, 8'h5a);
        wr(A_SCR_LANES, 8'h83);
        rd(A_SCR_LANES, 8'h83, 8'hff);
        wr(A_RES_M1, 8'h0f);
        wr(A_SUB_BITS, 8'h2f);
        wr(A_DENSITY, 8'h00);
        wr(A_XBAR_LO, xb[7:0]);
        wr(A_XBAR_HI, xb[15:8]);
        wr(A_INVERT, inv);
        wr(A_LANE_EN, en);
        wr(A_DESKEW, en);
        send = 1'b1;
        repeat (5) @(negedge core_clk_i);
        chk_byte(txm_count, 8'h00, "taken while off");
        send = 1'b0;
        wr(A_LINK_CTRL, 8'h01);
        chk_byte({7'h00, link_en}, 8'h01, "link on");
        run_phase("four lanes");
        wr(A_LINK_CTRL, 8'h00);
        {en, nl} = {8'h0e, 8'h01};
        wr(A_SCR_LANES, 8'h01);
        wr(A_LANE_EN, en);
        wr(A_LINK_CTRL, 8'h01);
        run_phase("two lanes");
        // Mid-run reset must bring every control back to its idle state
        rst_b_i = 1'b0;
        repeat (2) @(negedge core_clk_i);
        rst_b_i = 1'b1;
        chk_byte({3'h0, pll_en, cdr_rst, link_en, lane_ready, data_valid_o}, 8'h08, "after reset");
        rd(A_LINK_CTRL, 8'h00, 8'hff);
        rd(A_CDR_CFG, 8'h09, 8'hff);
        $display("test reset done");
        stop_test();
    end
endmodule
`default_nettype wire
